// ===== rtl/fcs_pkg.sv
// Shared constants, types and helpers of the flash command sequencer host
package fcs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_WP_NS = 50;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 150;
  localparam int T_DF_NS = 35;
  localparam int T_RST_US = 5;

  // Least time in ns to whole clock cycles, never below one
  function automatic int ns_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] T_WP_CYC = 8'(ns_cyc(T_WP_NS));
  localparam logic [7:0] T_WPH_CYC = 8'(ns_cyc(T_WPH_NS));
  localparam logic [7:0] T_ACC_CYC = 8'(ns_cyc(T_ACC_NS));
  localparam logic [7:0] T_DF_CYC = 8'(ns_cyc(T_DF_NS));
  localparam logic [7:0] US_CYC = 8'(CLK_MHZ);
  localparam logic [24:0] T_RST_LEN = 25'(T_RST_US);

  // ----------------------------------------------------------------
  // Device addresses and command bytes
  // ----------------------------------------------------------------
  localparam logic [18:0] ADR_UNLOCK1 = 19'h0_5555;
  localparam logic [18:0] ADR_UNLOCK2 = 19'h0_2AAA;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SE_CONF = 8'h30;
  localparam logic [7:0] CMD_BE_CONF = 8'h10;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;

  // Status bit positions in a byte read while the device is busy
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERR_BIT = 5;
  localparam int ETIMER_BIT = 3;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_TMO = 3;
  localparam int ST_RDATA_LSB = 8;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROG = 3'h1,
    OP_SERASE = 3'h2,
    OP_BERASE = 3'h3,
    OP_RESET = 3'h4,
    OP_IDENT = 3'h5
  } fcs_op_type;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } fcs_step_type;

  // Index of the last write cycle of each operation
  function automatic logic [2:0] fcs_last(input fcs_op_type op);
    unique case (op)
      OP_PROG: return 3'h3;
      OP_SERASE, OP_BERASE: return 3'h5;
      OP_IDENT: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction

  // Address and data of write cycle idx of an operation
  function automatic fcs_step_type fcs_step(input fcs_op_type op, input logic [2:0] idx,
                                            input logic [18:0] ua, input logic [7:0] ud);
    fcs_step_type s;
    s = '{addr: ADR_UNLOCK1, data: CMD_UNLOCK1};
    case (idx)
      3'h0, 3'h3: s = '{addr: ADR_UNLOCK1, data: CMD_UNLOCK1};
      3'h1, 3'h4: s = '{addr: ADR_UNLOCK2, data: CMD_UNLOCK2};
      3'h2: s.data = (op == OP_PROG) ? CMD_PROG : (op == OP_IDENT) ? CMD_IDENT : CMD_ERASE_SETUP;
      3'h5:
        if (op == OP_SERASE)
          s = '{addr: ua, data: CMD_SE_CONF};
      default: s = s;
    endcase
    if (op == OP_PROG && idx == 3'h3)
      s = '{addr: ua, data: ud};
    if (op == OP_BERASE && idx == 3'h5)
      s = '{addr: ADR_UNLOCK1, data: CMD_BE_CONF};
    if (op == OP_RESET)
      s = '{addr: ADR_UNLOCK1, data: CMD_RESET};
    return s;
  endfunction

  // Byte-lane merge for 32-bit register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

endpackage

// ===== rtl/fcs_cyc_if.sv
// Carrier between the sequencer and the flash bus cycle engine
`timescale 1ns/1ps
interface fcs_cyc_if;
  logic req;
  logic we;
  logic done;
  logic [18:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [18:0] pin_addr;
  logic [7:0] pin_dq_o;
  logic [7:0] pin_dq_i;
  logic pin_dq_oe;
  logic pin_ce_n;
  logic pin_oe_n;
  logic pin_we_n;

  modport ctl (
    output req, we, addr, wdata, pin_dq_i,
    input done, rdata, pin_addr, pin_dq_o, pin_dq_oe, pin_ce_n, pin_oe_n, pin_we_n
  );
  modport eng (
    input req, we, addr, wdata, pin_dq_i,
    output done, rdata, pin_addr, pin_dq_o, pin_dq_oe, pin_ce_n, pin_oe_n, pin_we_n
  );
endinterface

// ===== rtl/fcs_cyc_engine.sv
// One flash bus cycle, write or read, with pin timing
`timescale 1ns/1ps
module fcs_cyc_engine
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sequencer side and pins
  fcs_cyc_if.eng cif
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD, E_DONE} fcs_eng_type;

  fcs_eng_type st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [18:0] addr_q, addr_d;
  logic [7:0] dq_q, dq_d;
  logic [7:0] rd_q, rd_d;
  logic dq_oe_q, dq_oe_d;
  logic ce_n_q, ce_n_d;
  logic oe_n_q, oe_n_d;
  logic we_n_q, we_n_d;
  logic done_q, done_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    dq_d = dq_q;
    rd_d = rd_q;
    dq_oe_d = dq_oe_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    done_d = 1'b0;
    unique case (st_q)
      E_IDLE:
        if (cif.req)
        begin
          // Address settles a cycle before the strobe falls
          st_d = E_SETUP;
          wr_d = cif.we;
          addr_d = cif.addr;
          dq_d = cif.wdata;
          dq_oe_d = cif.we;
          ce_n_d = 1'b0;
        end
      E_SETUP:
      begin
        st_d = E_PULSE;
        cnt_d = (wr_q ? T_WP_CYC : T_ACC_CYC) - 8'h01;
        we_n_d = ~wr_q;
        oe_n_d = wr_q;
      end
      E_PULSE:
        if (cnt_q == 8'h00)
        begin
          if (!wr_q)
            rd_d = cif.pin_dq_i;
          // Data keeps driving past the rising strobe edge
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          cnt_d = (wr_q ? T_WPH_CYC : T_DF_CYC) - 8'h01;
          st_d = E_HOLD;
        end
        else
          cnt_d = cnt_q - 8'h01;
      E_HOLD:
        if (cnt_q == 8'h00)
        begin
          ce_n_d = 1'b1;
          dq_oe_d = 1'b0;
          done_d = 1'b1;
          st_d = E_DONE;
        end
        else
          cnt_d = cnt_q - 8'h01;
      E_DONE:
        st_d = E_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= E_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_q <= 19'h0_0000;
      dq_q <= 8'h00;
      rd_q <= 8'h00;
      dq_oe_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rd_q <= rd_d;
      dq_oe_q <= dq_oe_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      done_q <= done_d;
    end
  end

  assign cif.done = done_q;
  assign cif.rdata = rd_q;
  assign cif.pin_addr = addr_q;
  assign cif.pin_dq_o = dq_q;
  assign cif.pin_dq_oe = dq_oe_q;
  assign cif.pin_ce_n = ce_n_q;
  assign cif.pin_oe_n = oe_n_q;
  assign cif.pin_we_n = we_n_q;

endmodule // fcs_cyc_engine

// ===== rtl/fcs_us_timer.sv
// Microsecond down-counter with its own one-microsecond divider
`timescale 1ns/1ps
module fcs_us_timer
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic [24:0] len_i,
  output logic expired_o
);

  logic [7:0] div_q, div_d;
  logic [24:0] cnt_q, cnt_d;

  always_comb
  begin
    div_d = div_q;
    cnt_d = cnt_q;
    if (start_i)
    begin
      div_d = US_CYC - 8'h01;
      cnt_d = len_i;
    end
    else if (cnt_q != 25'h000_0000)
    begin
      if (div_q == 8'h00)
      begin
        div_d = US_CYC - 8'h01;
        cnt_d = cnt_q - 25'h000_0001;
      end
      else
        div_d = div_q - 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= 8'h00;
      cnt_q <= 25'h000_0000;
    end
    else
    begin
      div_q <= div_d;
      cnt_q <= cnt_d;
    end
  end

  assign expired_o = (cnt_q == 25'h000_0000);

endmodule // fcs_us_timer

// ===== rtl/fcs_flash_host.sv
// Flash command sequencer host: Wishbone registers to flash pin sequences
`timescale 1ns/1ps
module fcs_flash_host
  import fcs_pkg::*;
#(
  parameter logic [24:0] POLL_LIMIT_US = 25'h1C9_C380
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash pins
  output logic [18:0] flash_addr_o,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);

  typedef enum logic [2:0] {
    S_IDLE, S_WRITE, S_READ, S_POLL_A, S_POLL_B, S_FINAL, S_RST_CMD, S_RST_WAIT
  } fcs_state_type;

  fcs_cyc_if cif ();

  fcs_state_type st_q, st_d;
  fcs_op_type op_q, op_d;
  logic [2:0] idx_q, idx_d;
  logic [18:0] adr_q, adr_d;
  logic [7:0] wdat_q, wdat_d;
  logic [7:0] rdat_q, rdat_d;
  logic [7:0] prev_q, prev_d;
  logic chk_q, chk_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic tmo_q, tmo_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic tmr_start;
  logic [24:0] tmr_len;
  logic tmr_exp;
  logic acc;
  logic [31:0] wm;
  logic [31:0] wm_adr;
  logic [31:0] wm_wd;
  logic [7:0] diff;
  fcs_step_type step;

  // ----------------------------------------------------------------
  // Leaf blocks
  // ----------------------------------------------------------------
  fcs_cyc_engine u_eng (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif (cif)
  );

  fcs_us_timer u_tmr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .start_i (tmr_start),
    .len_i (tmr_len),
    .expired_o (tmr_exp)
  );

  // ----------------------------------------------------------------
  // Cycle requests
  // ----------------------------------------------------------------
  assign step = fcs_step(op_q, idx_q, adr_q, wdat_q);
  assign cif.req = (st_q != S_IDLE) && (st_q != S_RST_WAIT);
  assign cif.we = (st_q == S_WRITE) || (st_q == S_RST_CMD);
  // Reads always target the user address: the polled byte or erased sector
  assign cif.addr = (st_q == S_WRITE) ? step.addr :
                    (st_q == S_RST_CMD) ? ADR_UNLOCK1 : adr_q;
  assign cif.wdata = (st_q == S_RST_CMD) ? CMD_RESET : step.data;
  assign cif.pin_dq_i = flash_dq_i;

  // Only the toggle bit decides; reserved bits never enter the compare
  assign diff = (prev_q ^ cif.rdata) & (8'h01 << TOGGLE_BIT);

  // ----------------------------------------------------------------
  // Sequencer and register file next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    idx_d = idx_q;
    adr_d = adr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    prev_d = prev_q;
    chk_d = chk_q;
    done_d = done_q;
    fail_d = fail_q;
    tmo_d = tmo_q;
    tmr_start = 1'b0;
    tmr_len = POLL_LIMIT_US;
    acc = wb_cyc_i && wb_stb_i && !ack_q;
    ack_d = acc;
    dat_d = dat_q;
    wm = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
    wm_adr = wmerge({13'h0000, adr_q}, wb_dat_i, wb_sel_i);
    wm_wd = wmerge({24'h00_0000, wdat_q}, wb_dat_i, wb_sel_i);

    // Register access
    if (acc)
    begin
      dat_d = 32'h0000_0000;
      unique case (wb_adr_i)
        REG_CTRL: dat_d[2:0] = op_q;
        REG_ADDR: dat_d[18:0] = adr_q;
        REG_WDATA: dat_d[7:0] = wdat_q;
        REG_STATUS:
        begin
          dat_d[ST_BUSY] = (st_q != S_IDLE);
          dat_d[ST_DONE] = done_q;
          dat_d[ST_FAIL] = fail_q;
          dat_d[ST_TMO] = tmo_q;
          dat_d[ST_RDATA_LSB +: 8] = rdat_q;
        end
        default: dat_d = 32'h0000_0000;
      endcase
    end
    if (acc && wb_we_i && st_q == S_IDLE)
    begin
      if (wb_adr_i == REG_ADDR)
        adr_d = wm_adr[18:0];
      if (wb_adr_i == REG_WDATA)
        wdat_d = wm_wd[7:0];
      // Unknown op codes are dropped so no stray command reaches the flash
      if (wb_adr_i == REG_CTRL && wb_sel_i[0] && wm[2:0] <= OP_IDENT)
      begin
        op_d = fcs_op_type'(wm[2:0]);
        idx_d = 3'h0;
        chk_d = 1'b0;
        done_d = 1'b0;
        fail_d = 1'b0;
        tmo_d = 1'b0;
        st_d = (op_d == OP_READ) ? S_READ : S_WRITE;
      end
    end

    // Sequencer
    unique case (st_q)
      S_IDLE: ;
      S_WRITE:
        if (cif.done)
        begin
          if (idx_q == fcs_last(op_q))
          begin
            tmr_start = (op_q != OP_IDENT);
            unique case (op_q)
              OP_RESET:
              begin
                tmr_len = T_RST_LEN;
                st_d = S_RST_WAIT;
              end
              OP_IDENT: st_d = S_READ;
              // Status is valid only once the last write has ended
              default: st_d = S_POLL_A;
            endcase
          end
          else
            idx_d = idx_q + 3'h1;
        end
      S_READ:
        if (cif.done)
        begin
          rdat_d = cif.rdata;
          if (op_q == OP_IDENT)
            st_d = S_RST_CMD;
          else
          begin
            done_d = 1'b1;
            st_d = S_IDLE;
          end
        end
      S_POLL_A:
        if (cif.done)
        begin
          prev_d = cif.rdata;
          rdat_d = cif.rdata;
          st_d = S_POLL_B;
        end
      S_POLL_B:
        if (cif.done)
        begin
          rdat_d = cif.rdata;
          if (diff == 8'h00)
            st_d = S_FINAL;
          else if (tmr_exp)
          begin
            tmo_d = 1'b1;
            st_d = S_RST_CMD;
          end
          else if (cif.rdata[ERR_BIT])
          begin
            // Error bit may rise just as the job ends, so check once more
            fail_d = chk_q;
            chk_d = 1'b1;
            st_d = chk_q ? S_RST_CMD : S_POLL_A;
          end
          else
          begin
            chk_d = 1'b0;
            st_d = S_POLL_A;
          end
        end
      S_FINAL:
        if (cif.done)
        begin
          rdat_d = cif.rdata;
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      S_RST_CMD:
        if (cif.done)
        begin
          tmr_start = 1'b1;
          tmr_len = T_RST_LEN;
          st_d = S_RST_WAIT;
        end
      S_RST_WAIT:
        if (tmr_exp)
        begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      idx_q <= 3'h0;
      adr_q <= 19'h0_0000;
      wdat_q <= 8'h00;
      rdat_q <= 8'h00;
      prev_q <= 8'h00;
      chk_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      adr_q <= adr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      prev_q <= prev_d;
      chk_q <= chk_d;
      done_q <= done_d;
      fail_q <= fail_d;
      tmo_q <= tmo_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops here or in the cycle engine
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign flash_addr_o = cif.pin_addr;
  assign flash_dq_o = cif.pin_dq_o;
  assign flash_dq_oe_o = cif.pin_dq_oe;
  assign flash_ce_n_o = cif.pin_ce_n;
  assign flash_oe_n_o = cif.pin_oe_n;
  assign flash_we_n_o = cif.pin_we_n;

endmodule // fcs_flash_host

// ===== test/fcs_flash_host_props.sv
// Checker of the flash host register bus and flash pins
`timescale 1ns/1ps
module fcs_flash_host_props
  import fcs_pkg::*;
#(
  parameter logic [24:0] POLL_LIMIT_US = 25'h1C9_C380
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Flash pins
  input wire logic [18:0] flash_addr_o,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic [7:0] flash_dq_i,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h0C
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_strobe_excl: assert property (!(!flash_we_n_o && !flash_oe_n_o))
    else $error("write and read strobes together");
  a_strobe_sel: assert property (!(flash_we_n_o && flash_oe_n_o) |-> !flash_ce_n_o)
    else $error("strobe without select");
  a_read_nodrive: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
    else $error("host drives dq in read");
  a_addr_setup: assert property ($fell(flash_we_n_o) |-> $stable(flash_addr_o))
    else $error("address moves at strobe fall");
  a_we_width: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*8])
    else $error("write pulse short");
  a_data_hold: assert property ($rose(flash_we_n_o) |-> !flash_ce_n_o && flash_dq_oe_o
    && $stable(flash_dq_o)) else $error("data not held");
  a_unlock_data: assert property ($fell(flash_we_n_o) && flash_addr_o == 19'h0_2AAA
    |-> flash_dq_o == 8'h55) else $error("second unlock data");
  a_ce_gap: assert property ($rose(flash_ce_n_o) |=> flash_ce_n_o)
    else $error("select gap short");

  c_write: cover property ($fell(flash_we_n_o));
  c_read: cover property ($fell(flash_oe_n_o));
  c_reg_wr: cover property (wb_ack_o && wb_we_i);
endmodule // fcs_flash_host_props

// ===== test/fcs_flash_model.sv
// Behavioural flash device facing the host pins
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [7:0] MAKER = 8'h3C, // Arbitrary code
  parameter logic [7:0] DEVID = 8'h7E, // Arbitrary code
  parameter logic [7:0] PROT = 8'h80,
  parameter int BUSY_RD = 4
)
(
  // Pins
  input wire logic [18:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [7:0] dq_o,
  // Fault injection
  input wire logic err_inj_i,
  input wire logic stuck_i
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] drv = 8'h00;
  logic [18:0] alat;
  logic [18:0] padr;
  logic [7:0] pdat;
  logic busy = 0, ers = 0, bulk = 0, ident = 0, tog = 0, err = 0, etim = 1;
  int step = 0;
  int left = 0;

  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // Released bus shows the inverse of the last value, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? drv : ~drv;

  task automatic start(input logic e, input logic b, input logic [18:0] a, input logic [7:0] d);
    busy = 1;
    ers = e;
    bulk = b;
    padr = a;
    pdat = d;
    left = BUSY_RD;
    etim = !e || b;
  endtask

  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    if (d == 8'hF0)
    begin
      busy = 0;
      err = 0;
      ident = 0;
      step = 0;
    end
    else if (!busy)
      case (step)
        0, 3: step = (a == 19'h0_5555 && d == 8'hAA) ? step + 1 : 0;
        1, 4: step = (a == 19'h0_2AAA && d == 8'h55) ? step + 1 : 0;
        2:
        begin
          ident = (a == 19'h0_5555 && d == 8'h90);
          step = (a != 19'h0_5555) ? 0 : (d == 8'hA0) ? 9 : (d == 8'h80) ? 3 : 0;
        end
        5:
        begin
          step = 0;
          if (d == 8'h30)
            start(1, 0, a, d);
          else if (a == 19'h0_5555 && d == 8'h10)
            start(1, 1, a, d);
        end
        9:
        begin
          step = 0;
          if (!PROT[a[18:16]])
            start(0, 0, a, d);
        end
        default: step = 0;
      endcase
  endtask

  always @(negedge we_n_i) if (!ce_n_i) alat = addr_i;
  always @(posedge we_n_i) if (!ce_n_i) cmd(alat, dq_i);

  always @(negedge oe_n_i)
  begin
    if (ce_n_i)
      ;
    else if (busy)
    begin
      err = err || err_inj_i;
      tog = !tog;
      drv = {ers ? 1'b0 : !pdat[7], tog, err, 1'b1, etim, 3'b101};
      etim = 1;
      left = left - 1;
      if (left <= 0 && !err_inj_i && !stuck_i)
      begin
        busy = 0;
        if (!ers)
          mem[padr] = rd(padr) & pdat;
        else
          foreach (mem[k])
            if (!PROT[k[18:16]] && (bulk || k[18:16] == padr[18:16]))
              mem[k] = 8'hFF;
      end
    end
    else if (ident)
      drv = addr_i[6] ? 8'h00 : addr_i[1] ? {7'h0, PROT[addr_i[18:16]]}
        : addr_i[0] ? DEVID : MAKER;
    else
      drv = rd(addr_i);
  end
endmodule // fcs_flash_model

// ===== test/testbench.sv
// Self-checking bench of the flash command sequencer host
`timescale 1ns/1ps
module testbench;
  import fcs_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, s;
  logic wb_ack_o, dq_oe, ce_n, oe_n, we_n, err_inj = 0, stuck = 0;
  logic [18:0] faddr;
  logic [7:0] fdq_o, fm_dq, fdq;
  logic [18:0] ida [4] = '{19'h0_0000, 19'h0_0001, 19'h7_0002, 19'h1_0002};
  logic [7:0] idv [4] = '{8'h3C, 8'h7E, 8'h01, 8'h00};
  int n_fail = 0, tests_run = 0, cyc_n = 0;

  initial forever #2 clk_i = ~clk_i;
  assign fdq = dq_oe ? fdq_o : fm_dq;

  fcs_flash_host #(.POLL_LIMIT_US(25'd20)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_addr_o(faddr), .flash_dq_o(fdq_o),
    .flash_dq_oe_o(dq_oe), .flash_dq_i(fdq), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n));
  fcs_flash_model #(.MAKER(8'h3C), .DEVID(8'h7E)) FM (
    .addr_i(faddr), .dq_i(fdq), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_o(fm_dq), .err_inj_i(err_inj), .stuck_i(stuck));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
    @(posedge clk_i);
  endtask

  task automatic op(input logic [2:0] o, input logic [18:0] a, input logic [7:0] d);
    xfer(1, REG_ADDR, 32'(a), s);
    xfer(1, REG_WDATA, 32'(d), s);
    xfer(1, REG_CTRL, 32'(o), s);
    do xfer(0, REG_STATUS, '0, s); while (s[ST_BUSY] !== 1'b0);
  endtask

  function automatic logic [31:0] st(input logic [7:0] b);
    return {16'h0000, b, 8'h02};
  endfunction

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    xfer(0, REG_STATUS, '0, s);
    chk(s, '0);
    xfer(0, 8'h10, '0, s);
    chk(s, '0);
    xfer(1, REG_CTRL, 32'h0000_0007, s);
    xfer(0, REG_STATUS, '0, s);
    chk(s, '0);
    $display("test reset and map done");
    op(OP_PROG, 19'h1_2345, 8'h5A);
    chk(s, st(8'h5A));
    op(OP_PROG, 19'h7_0010, 8'h00);
    chk(s, st(8'hFF));
    op(OP_SERASE, 19'h1_0000, 8'h00);
    chk(s, st(8'hFF));
    op(OP_PROG, 19'h1_2345, 8'h3C);
    chk(s, st(8'h3C));
    op(OP_READ, 19'h1_2345, 8'h00);
    chk(s, st(8'h3C));
    op(OP_SERASE, 19'h7_0000, 8'h00);
    chk(s, st(8'hFF));
    op(OP_BERASE, 19'h1_2345, 8'h00);
    chk(s, st(8'hFF));
    $display("test program and erase done");
    err_inj <= 1;
    op(OP_PROG, 19'h2_0000, 8'h11);
    chk(s[ST_FAIL], 1);
    chk(FM.err, 0);
    err_inj <= 0;
    stuck <= 1;
    op(OP_PROG, 19'h2_0001, 8'h22);
    chk(s[ST_TMO], 1);
    stuck <= 0;
    op(OP_RESET, 19'h0_0000, 8'h00);
    chk(s[1:0], 2'b10);
    $display("test error timeout reset done");
    foreach (ida[i])
    begin
      op(OP_IDENT, ida[i], 8'h00);
      chk(s[15:8], idv[i]);
    end
    $display("test ident done");
    close_out();
  end
endmodule // testbench

bind fcs_flash_host fcs_flash_host_props #(.POLL_LIMIT_US(POLL_LIMIT_US)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i),
  .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o));
